// *** design/special_command_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module special_command_decoder
  import spc_pkg::*;
#(
  parameter logic [7:0] FW_VERSION = FW_VERSION_DEFAULT
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [11:0] acc_addr,
  input wire logic [7:0] converter_format_mirror,
  input wire logic [7:0] converter_rate_mirror,
  input wire logic [7:0] converter_acquisition_mirror,
  input wire logic [7:0] serial_port_config_mirror,
  input wire logic [15:0] temperature_scaling_coefficient,
  input wire logic sensor_done,
  input wire logic [15:0] sensor_raw,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic busy,
  output logic mirror_load,
  output logic [7:0] hw_format,
  output logic [7:0] hw_rate,
  output logic [7:0] hw_acquisition,
  output logic [7:0] hw_serial_config,
  output logic sensor_start,
  output logic halted,
  output logic reduced_power_state
);

  // ****************************************
  // Decode
  // ****************************************
  cmd_state_t state_r;
  cmd_state_t state_nxt;
  logic rd_take;
  logic hit_upd_hw;
  logic hit_hw_to_mirror_command;
  logic hit_ver;
  logic hit_temp;
  logic hit_halt;
  logic hit_lp_in;
  logic hit_lp_out;
  logic hit_any;
  logic conv_done;
  logic [7:0] conv_celsius;
  logic rd_valid_nxt;
  logic [7:0] rd_data_nxt;

  assign rd_take = acc_valid && !acc_write && (state_r == ST_IDLE); // [RULE1] [RULE12]
  assign hit_upd_hw = rd_take && (acc_addr == MIRROR_TO_HW_COMMAND);
  assign hit_hw_to_mirror_command = rd_take && (acc_addr == HW_TO_MIRROR_COMMAND);
  assign hit_ver = rd_take && (acc_addr == FIRMWARE_VERSION_QUERY);
  assign hit_temp = rd_take && (acc_addr == TEMPERATURE_READ_COMMAND);
  assign hit_halt = rd_take && (acc_addr == HALT_ENTRY_COMMAND);
  assign hit_lp_in = rd_take && (acc_addr == REDUCED_POWER_ENTRY_COMMAND);
  assign hit_lp_out = rd_take && (acc_addr == REDUCED_POWER_EXIT_COMMAND);
  assign hit_any = hit_upd_hw || hit_hw_to_mirror_command || hit_ver || hit_halt || hit_lp_in || hit_lp_out;

  // ****************************************
  // Answer
  // ****************************************
  assign rd_valid_nxt = hit_any || conv_done; // [RULE1] [RULE5]
  assign rd_data_nxt = conv_done ? conv_celsius : // [RULE6]
                       hit_ver ? FW_VERSION : DUMMY_BYTE; // [RULE4] [RULE2] [RULE3] [RULE10]
  assign state_nxt = hit_temp ? ST_WAIT : (conv_done ? ST_IDLE : state_r); // [RULE5]

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      busy <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rd_valid <= rd_valid_nxt;
      rd_data <= rd_data_nxt;
      busy <= (state_nxt == ST_WAIT);
    end
  end

  // ****************************************
  // Hardware registers and mirror copy
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hw_format <= HW_REG_RESET;
      hw_rate <= HW_REG_RESET;
      hw_acquisition <= HW_REG_RESET;
      hw_serial_config <= HW_REG_RESET;
      mirror_load <= 1'b0;
    end
    else
    begin
      mirror_load <= hit_hw_to_mirror_command; // [RULE3]
      if (hit_upd_hw)
      begin
        hw_format <= converter_format_mirror; // [RULE2]
        hw_rate <= converter_rate_mirror;
        hw_acquisition <= converter_acquisition_mirror;
        hw_serial_config <= serial_port_config_mirror;
      end
    end
  end

  // ****************************************
  // Power states
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      halted <= 1'b0;
      reduced_power_state <= 1'b0;
    end
    else
    begin
      if (hit_halt)
      begin
        halted <= 1'b1; // [RULE8]
      end
      if (hit_lp_in)
      begin
        reduced_power_state <= 1'b1; // [RULE9]
      end
      else if (hit_lp_out)
      begin
        reduced_power_state <= 1'b0; // [RULE10]
      end
    end
  end

  // ****************************************
  // Temperature conversion
  // ****************************************
  temp_converter u_temp
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(hit_temp),
    .sensor_done(sensor_done && (state_r == ST_WAIT)),
    .sensor_raw(sensor_raw),
    .temperature_scaling_coefficient(temperature_scaling_coefficient),
    .sensor_start(sensor_start),
    .conv_done(conv_done),
    .celsius(conv_celsius)
  );

  // ****************************************
  // Checks
  // ****************************************
  AST_RO_READ: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    (rd_take && (hit_any || hit_temp)) |=> (rd_valid || busy))
    else $error("command read produced neither answer nor wait");

  AST_UPD_HW: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    hit_upd_hw |=> (hw_format == $past(converter_format_mirror))
      && (hw_serial_config == $past(serial_port_config_mirror)) && rd_valid)
    else $error("mirror to hardware copy failed");

  AST_HW_TO_MIRROR_COMMAND: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    hit_hw_to_mirror_command |=> mirror_load && rd_valid ##1 !mirror_load)
    else $error("hardware to mirror load not a single pulse");

  AST_VERSION: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
    hit_ver |=> rd_valid && (rd_data == FW_VERSION))
    else $error("wrong firmware version answer");

  AST_TEMP_START: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    hit_temp |=> sensor_start && busy && !rd_valid)
    else $error("temperature read did not start conversion");

  AST_TEMP_NO_EARLY: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    (state_r == ST_WAIT) && !conv_done |=> !rd_valid)
    else $error("temperature answered before conversion end");

  AST_TEMP_RESULT: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
    conv_done |=> rd_valid && (rd_data == $past(conv_celsius)) && !busy)
    else $error("temperature result not delivered");

  AST_HALT: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    hit_halt |=> halted [*2])
    else $error("halt not entered");

  AST_LP_ENTER: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
    hit_lp_in |=> reduced_power_state)
    else $error("reduced power not entered");

  AST_LP_EXIT: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    hit_lp_out |=> !reduced_power_state && rd_valid)
    else $error("reduced power not left");

  AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
    (acc_valid && acc_write && (state_r == ST_IDLE)) |=> !rd_valid && !mirror_load
      && !sensor_start && $stable(hw_format) && $stable(reduced_power_state))
    else $error("write to command address had an effect");

  AST_BUSY_IGNORES: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    (acc_valid && busy && !conv_done) |=> !rd_valid && !mirror_load && !sensor_start
      && $stable(hw_format) && $stable(halted) && $stable(reduced_power_state))
    else $error("access while busy had an effect");

  AST_DUMMY_ANSWER: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    (hit_upd_hw || hit_hw_to_mirror_command || hit_halt || hit_lp_in || hit_lp_out)
      |=> rd_valid && (rd_data == DUMMY_BYTE))
    else $error("command answer is not the dummy byte");

  AST_HW_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    !hit_upd_hw |=> $stable(hw_format) && $stable(hw_rate)
      && $stable(hw_acquisition) && $stable(hw_serial_config))
    else $error("hardware register changed without copy command");

  AST_HALT_STAYS: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    halted |=> halted)
    else $error("halt state left without reset");

endmodule
`default_nettype wire

// *** common/spc_pkg.sv ***
// Behaviour
// [RULE1] Command addresses are read-only triggering virtual registers
// [RULE2] Read 0x900 copies mirrors into hardware registers
// [RULE3] Read 0xA00 copies hardware registers into mirrors
// [RULE4] Read 0xC00 returns firmware version
// [RULE5] Read 0xC01 converts temperature, answers when done
// [RULE6] Temperature answer in whole degrees Celsius
// [RULE7] Master programs scaling coefficient before temperature read
// [RULE8] Read 0xC02 enters halt state
// [RULE9] Read 0xC03 enters reduced-power state
// [RULE10] Read 0xC04 leaves reduced-power, returns one byte
// [RULE11] Shared bus needs one select per device
// [RULE12] Writes to command addresses are ignored
//
package spc_pkg;

  // ****************************************
  // Command addresses
  // ****************************************
  localparam logic [11:0] MIRROR_TO_HW_COMMAND = 12'h900;
  localparam logic [11:0] HW_TO_MIRROR_COMMAND = 12'hA00;
  localparam logic [11:0] FIRMWARE_VERSION_QUERY = 12'hC00;
  localparam logic [11:0] TEMPERATURE_READ_COMMAND = 12'hC01;
  localparam logic [11:0] HALT_ENTRY_COMMAND = 12'hC02;
  localparam logic [11:0] REDUCED_POWER_ENTRY_COMMAND = 12'hC03;
  localparam logic [11:0] REDUCED_POWER_EXIT_COMMAND = 12'hC04;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [7:0] HW_REG_RESET = 8'h00;
  localparam logic [7:0] FW_VERSION_DEFAULT = 8'h01;
  localparam int TEMP_FRAC_BITS = 16;
  localparam logic signed [16:0] TEMP_MAX_DEG = 17'sh0007F;
  localparam logic signed [16:0] TEMP_MIN_DEG = -17'sh00080;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } cmd_state_t;

endpackage

// *** design/temp_converter.sv ***
`timescale 1ns/100ps
`default_nettype none
module temp_converter
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic sensor_done,
  input wire logic [15:0] sensor_raw,
  input wire logic [15:0] temperature_scaling_coefficient,
  output logic sensor_start,
  output logic conv_done,
  output logic [7:0] celsius
);

  // ****************************************
  // Scaling to whole degrees
  // ****************************************
  logic signed [32:0] product;
  logic signed [16:0] degrees;
  logic [7:0] celsius_nxt;

  assign product = $signed(sensor_raw) * $signed({1'b0, temperature_scaling_coefficient});
  assign degrees = 17'(product >>> TEMP_FRAC_BITS); // [RULE6]
  assign celsius_nxt = (degrees > TEMP_MAX_DEG) ? 8'h7F :
                       (degrees < TEMP_MIN_DEG) ? 8'h80 : degrees[7:0]; // [RULE6]

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sensor_start <= 1'b0;
      conv_done <= 1'b0;
      celsius <= 8'h00;
    end
    else
    begin
      sensor_start <= start; // [RULE5]
      conv_done <= sensor_done;
      if (sensor_done)
      begin
        celsius <= celsius_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// *** verif/sensor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sensor_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sensor_start,
  input wire logic [15:0] raw_value,
  input wire logic [7:0] delay,
  output logic sensor_done,
  output logic [15:0] sensor_raw
);
  // ****************************************
  // Conversion with programmable latency
  // ****************************************
  logic run_r;
  logic [7:0] count_r;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_r <= 1'b0;
      count_r <= 8'h00;
      sensor_done <= 1'b0;
      sensor_raw <= 16'h0000;
    end
    else if (run_r && count_r == 8'h00)
    begin
      run_r <= 1'b0;
      sensor_done <= 1'b1;
      sensor_raw <= raw_value;
    end
    else
    begin
      run_r <= run_r | sensor_start;
      count_r <= sensor_start ? delay : count_r - {7'h00, run_r};
      sensor_done <= 1'b0;
      sensor_raw <= ~sensor_raw;
    end
  end
endmodule
`default_nettype wire

// *** verif/special_command_decoder_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module special_command_decoder_bench;
  import spc_pkg::*;
  localparam logic [7:0] FW = 8'h5A;
  logic clk, sys_rst, acc_valid, acc_write, sensor_done, rd_valid, busy, mirror_load;
  logic sensor_start, halted, reduced_power_state, seen, load_seen, busy_seen;
  logic [11:0] acc_addr;
  logic [7:0] fmt, rate, acq, spc, rd_data, hw_format, hw_rate, hw_acquisition;
  logic [7:0] hw_serial_config, delay, got;
  logic [15:0] coeff, raw_value, sensor_raw;
  logic [11:0] cmds [0:6] = '{MIRROR_TO_HW_COMMAND, HW_TO_MIRROR_COMMAND,
    FIRMWARE_VERSION_QUERY, TEMPERATURE_READ_COMMAND, HALT_ENTRY_COMMAND,
    REDUCED_POWER_ENTRY_COMMAND, REDUCED_POWER_EXIT_COMMAND};
  logic [15:0] raws [0:3] = '{16'h1900, 16'hFF00, 16'h8000, 16'h7FFF};
  logic [7:0] temps [0:3] = '{8'h19, 8'hFF, 8'h80, 8'h7F};
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  special_command_decoder #(.FW_VERSION(FW)) dut (.clk(clk), .sys_rst(sys_rst),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .converter_format_mirror(fmt), .converter_rate_mirror(rate),
    .converter_acquisition_mirror(acq), .serial_port_config_mirror(spc),
    .temperature_scaling_coefficient(coeff), .sensor_done(sensor_done),
    .sensor_raw(sensor_raw), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
    .mirror_load(mirror_load), .hw_format(hw_format), .hw_rate(hw_rate),
    .hw_acquisition(hw_acquisition), .hw_serial_config(hw_serial_config),
    .sensor_start(sensor_start), .halted(halted),
    .reduced_power_state(reduced_power_state));
  sensor_model sensor (.clk(clk), .sys_rst(sys_rst), .sensor_start(sensor_start),
    .raw_value(raw_value), .delay(delay), .sensor_done(sensor_done),
    .sensor_raw(sensor_raw));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic access(input logic [11:0] addr, input logic wr);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_addr <= addr;
    @(posedge clk);
    acc_valid <= 1'b0;
    seen = 1'b0;
    load_seen = 1'b0;
    busy_seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++)
    begin
      #1;
      busy_seen = busy_seen | (busy === 1'b1);
      seen = (rd_valid === 1'b1);
      got = rd_data;
      load_seen = mirror_load;
      if (!seen)
        @(posedge clk);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 12'h000;
    {fmt, rate, acq, spc} = 32'h3C5AA5C3;
    coeff = 16'h0100;
    raw_value = 16'h0000;
    delay = 8'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      access(cmds[i], 1'b1);
      chk("write answer", 0, {seen, busy_seen});
    end
    chk("hw regs", 0, {hw_format, hw_rate, hw_acquisition, hw_serial_config});
    chk("states", 0, {halted, reduced_power_state});
    access(12'hC05, 1'b0);
    chk("unmapped answer", 0, seen);
    access(FIRMWARE_VERSION_QUERY, 1'b0);
    chk("version", {1'b1, FW}, {seen, got});
    access(MIRROR_TO_HW_COMMAND, 1'b0);
    chk("copy answer", {1'b1, DUMMY_BYTE}, {seen, got});
    chk("hw regs", 32'h3C5AA5C3, {hw_format, hw_rate, hw_acquisition, hw_serial_config});
    access(HW_TO_MIRROR_COMMAND, 1'b0);
    chk("copy back", {2'b11, DUMMY_BYTE}, {seen, load_seen, got});
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      raw_value <= raws[i];
      delay <= 8'(i * 15);
      coeff <= (i == 3) ? 16'h0200 : 16'h0100;
      fork
        access(TEMPERATURE_READ_COMMAND, 1'b0);
        begin
          repeat (4) @(posedge clk);
          acc_valid <= 1'b1;
          acc_addr <= HALT_ENTRY_COMMAND;
          @(posedge clk);
          acc_valid <= 1'b0;
        end
      join
      chk("temperature", {2'b11, temps[i]}, {seen, busy_seen, got});
      chk("busy refusal", 0, halted);
    end
    access(REDUCED_POWER_ENTRY_COMMAND, 1'b0);
    chk("enter reduced", 2'b11, {seen, reduced_power_state});
    access(REDUCED_POWER_EXIT_COMMAND, 1'b0);
    chk("exit reduced", {2'b10, DUMMY_BYTE}, {seen, reduced_power_state, got});
    access(HALT_ENTRY_COMMAND, 1'b0);
    chk("halt", 2'b11, {seen, halted});
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("after reset", 0, {halted, reduced_power_state, busy, rd_valid, hw_format});
    access(FIRMWARE_VERSION_QUERY, 1'b0);
    chk("version after reset", {1'b1, FW}, {seen, got});
    give_verdict();
  end
endmodule
`default_nettype wire
